/* rtie_top.sv */
/*
 * Remote terminal interrupt event registers: enable, pending and output
 * enable with one shared bit layout, the host interrupt line and the
 * reset-request pin. Assumes the protocol engine delivers decoded
 * command strobes and a message-done strobe on CLK_IN.
 */
// How it works
// - one bit layout for all three registers
// - bits 15..9 ignore writes, read zero
// - bits 2..0 ignore writes, read zero
// - bit 8 flags valid reset mode command
// - disabled reset command drives reset-request pin
// - broadcast reset command also drives reset-request pin
// - bit 7 on indexed count 1 to 0
// - bit 7 on circular message count reached
// - bit 6 on command with illegal entry
// - illegal command: status with error, no data
// - disabled illegal command leaves pending bit 6 alone; bit 4 still sets if enabled and can arm the line
// - bit 5 on enabled broadcast command
// - bit 4 when message error flag set
// - bit 3 on command with access option
// - enabled events OR into pending
// - pending read returns value then clears
// - enabled output asserts line at message end
// - late enable ignores earlier events
module rtie_top (
    input wire logic CLK_IN,                    // 10 MHz clock
    input wire logic ARST_N_IN,                 // async reset, active low
    input rtie_pkg::rtie_host_s HOST_IN,        // host register access
    input rtie_pkg::rtie_cmd_s CMD_IN,          // decoded command
    input wire logic BCAST_EN_IN,               // broadcast allowed
    input wire logic INDEX_ZERO_IN,             // indexed count hit 0
    input wire logic CIRC_DONE_IN,              // circular count reached
    input wire logic ME_SET_IN,                 // message error set
    input wire logic MSG_DONE_IN,               // message completion
    input wire logic CFG_AUTO_RESET_IN,         // config bit 0
    input wire logic RESET_ACK_IN,              // reset request served
    output logic [rtie_pkg::DATA_W-1:0] RD_DATA_OUT, // read data
    output logic IRQ_N_OUT,                     // host interrupt, low
    output logic RESET_REQ_OUT,                 // terminal reset request
    output logic RESET_AUTO_OUT,                // reset handled by itself
    output logic ME_FLAG_OUT,                   // status message error
    output logic NO_DATA_OUT                    // send status word only
);

    typedef struct packed {
        logic [rtie_pkg::DATA_W-1:0] enable;
        logic [rtie_pkg::DATA_W-1:0] out_en;
        logic [rtie_pkg::DATA_W-1:0] rd_data;
        logic arm;
        logic irq_n;
        logic rst_req;
        logic rst_auto;
        logic me_flag;
        logic no_data;
    } rtie_state_s;

    rtie_state_s st;
    rtie_state_s next_st;
    logic [rtie_pkg::DATA_W-1:0] events;
    logic [rtie_pkg::DATA_W-1:0] taken;
    logic [rtie_pkg::DATA_W-1:0] pending;
    logic pend_read;
    logic reset_cmd;
    logic illegal_cmd;

    assign reset_cmd = CMD_IN.valid && CMD_IN.reset_mc;
    assign illegal_cmd = CMD_IN.valid && CMD_IN.illegal;
    assign pend_read = HOST_IN.rd && HOST_IN.addr == rtie_pkg::PENDING_ADDR;

    // raw events, each at its own position in the shared layout
    always_comb
    begin
        events = '0;
        events[rtie_pkg::RESET_CMD_BIT] = reset_cmd;
        events[rtie_pkg::INDEX_ZERO_BIT] =
            INDEX_ZERO_IN || CIRC_DONE_IN;
        events[rtie_pkg::ILLEGAL_CMD_BIT] =
            illegal_cmd;
        events[rtie_pkg::BROADCAST_RX_BIT] = CMD_IN.valid &&
            BCAST_EN_IN && CMD_IN.bcast_addr;
        // an illegal reply sets the error flag, so it counts as well
        events[rtie_pkg::MSG_ERROR_BIT] =
            ME_SET_IN || illegal_cmd;
        events[rtie_pkg::ACCESS_NOTIFY_BIT] =
            CMD_IN.valid && CMD_IN.access_opt;
    end

    // gated by the enable as it stands now: nothing is kept for a
    // disabled event, so a later enable sees no history
    assign taken = events & st.enable;

    rtie_sticky #(
        .W(rtie_pkg::DATA_W)
    ) u_pending (
        .clk_in(CLK_IN),
        .arst_n_in(ARST_N_IN),
        .set_in(taken),
        .clr_in(pend_read),
        .q_out(pending)
    );

    always_comb
    begin
        next_st = st;
        if (HOST_IN.wr && HOST_IN.addr == rtie_pkg::ENABLE_ADDR)
            next_st.enable = HOST_IN.wdata & rtie_pkg::LIVE_MASK;
        if (HOST_IN.wr && HOST_IN.addr == rtie_pkg::OUT_ENABLE_ADDR)
            next_st.out_en = HOST_IN.wdata & rtie_pkg::LIVE_MASK;
        if (HOST_IN.rd)
        begin
            case (HOST_IN.addr)
                rtie_pkg::PENDING_ADDR: next_st.rd_data = pending;
                rtie_pkg::ENABLE_ADDR: next_st.rd_data = st.enable;
                rtie_pkg::OUT_ENABLE_ADDR: next_st.rd_data = st.out_en;
                default: next_st.rd_data = '0;
            endcase
        end
        // events enabled in the output enable arm the line; it fires at message end
        if (MSG_DONE_IN)
        begin
            next_st.arm = 1'b0;
            if (st.arm || |(taken & st.out_en))
                next_st.irq_n = 1'b0;
        end
        else if (|(taken & st.out_en))
        begin
            next_st.arm = 1'b1;
        end
        else if (pend_read)
        begin
            next_st.irq_n = 1'b1;
        end
        if (RESET_ACK_IN)
            next_st.rst_req = 1'b0;
        if (reset_cmd &&
            (!st.enable[rtie_pkg::RESET_CMD_BIT] || CMD_IN.bcast_addr))
        begin
            next_st.rst_req = 1'b1;
            next_st.rst_auto = CFG_AUTO_RESET_IN;
        end
        if (MSG_DONE_IN)
        begin
            next_st.me_flag = 1'b0;
            next_st.no_data = 1'b0;
        end
        if (illegal_cmd)
        begin
            next_st.me_flag = 1'b1;
            next_st.no_data = 1'b1;
        end
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            st <= '0;
            st.enable <= rtie_pkg::REG_RESET;
            st.out_en <= rtie_pkg::REG_RESET;
            st.irq_n <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign RD_DATA_OUT = st.rd_data;
    assign IRQ_N_OUT = st.irq_n;
    assign RESET_REQ_OUT = st.rst_req;
    assign RESET_AUTO_OUT = st.rst_auto;
    assign ME_FLAG_OUT = st.me_flag;
    assign NO_DATA_OUT = st.no_data;

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);

    chk_reserved_reads_zero: assert property (
        (RD_DATA_OUT & ~rtie_pkg::LIVE_MASK) == '0)
        else $error("reserved bit reads nonzero");

    chk_pending_or_set: assert property (
        !pend_read |=> (pending & $past(taken | pending)) ==
            $past(taken | pending))
        else $error("pending lost or missed a bit");

    chk_read_clears: assert property (
        pend_read && taken == '0 |=> pending == '0 &&
            RD_DATA_OUT == $past(pending))
        else $error("pending read did not return then clear");

    chk_illegal_masked: assert property (
        CMD_IN.valid && CMD_IN.illegal && !pend_read &&
        !st.enable[rtie_pkg::ILLEGAL_CMD_BIT] |=>
            pending[rtie_pkg::ILLEGAL_CMD_BIT] ==
            $past(pending[rtie_pkg::ILLEGAL_CMD_BIT]))
        else $error("disabled illegal command touched pending");

    chk_reset_pin: assert property (
        reset_cmd && (!st.enable[rtie_pkg::RESET_CMD_BIT] ||
        CMD_IN.bcast_addr) |=> RESET_REQ_OUT &&
            RESET_AUTO_OUT == $past(CFG_AUTO_RESET_IN))
        else $error("reset request pin not raised");

    chk_reset_event: assert property (
        reset_cmd && st.enable[rtie_pkg::RESET_CMD_BIT] |=>
            pending[rtie_pkg::RESET_CMD_BIT])
        else $error("reset command event not pending");

    chk_irq_at_done: assert property (
        MSG_DONE_IN && (st.arm || |(taken & st.out_en)) |=> !IRQ_N_OUT)
        else $error("interrupt line not asserted at message end");

    chk_irq_only_done: assert property (
        $fell(IRQ_N_OUT) |-> $past(MSG_DONE_IN))
        else $error("interrupt line fell outside message end");

    chk_illegal_reply: assert property (
        CMD_IN.valid && CMD_IN.illegal |=> ME_FLAG_OUT && NO_DATA_OUT)
        else $error("illegal command reply not status only");

    chk_bcast_event: assert property (
        CMD_IN.valid && CMD_IN.bcast_addr && BCAST_EN_IN &&
        st.enable[rtie_pkg::BROADCAST_RX_BIT] |=>
            pending[rtie_pkg::BROADCAST_RX_BIT])
        else $error("broadcast event not pending");

    chk_index_event: assert property (
        (INDEX_ZERO_IN || CIRC_DONE_IN) &&
        st.enable[rtie_pkg::INDEX_ZERO_BIT] |=>
            pending[rtie_pkg::INDEX_ZERO_BIT])
        else $error("index zero event not pending");

    cov_irq_fired: cover property (MSG_DONE_IN ##1 !IRQ_N_OUT);
    cov_read_clear: cover property (pend_read && pending != '0);
    cov_reset_req: cover property ($rose(RESET_REQ_OUT));
    cov_illegal: cover property ($rose(NO_DATA_OUT));

endmodule

/* rtie_pkg.sv */
/*
 * Shared constants and carrier types for the terminal interrupt event
 * block. Assumes the host port decoder presents word addresses at the
 * register offsets held here.
 */
package rtie_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;

    // register offsets on the host port (word addresses)
    localparam logic [ADDR_W-1:0] PENDING_ADDR = 8'h09;
    localparam logic [ADDR_W-1:0] ENABLE_ADDR = 8'h12;
    localparam logic [ADDR_W-1:0] OUT_ENABLE_ADDR = 8'h16;

    // shared event bit layout of all three registers
    localparam int RESET_CMD_BIT = 8;
    localparam int INDEX_ZERO_BIT = 7;
    localparam int ILLEGAL_CMD_BIT = 6;
    localparam int BROADCAST_RX_BIT = 5;
    localparam int MSG_ERROR_BIT = 4;
    localparam int ACCESS_NOTIFY_BIT = 3;

    // only bits 8..3 hold state; 15..9 and 2..0 read as zero
    localparam logic [DATA_W-1:0] LIVE_MASK = 16'h01F8;
    localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;

    // one decoded command word, qualified by valid
    typedef struct packed {
        logic valid;        // one-cycle strobe: valid command decoded
        logic reset_mc;     // command is the reset-terminal mode command
        logic illegal;      // illegalization table entry is 1
        logic bcast_addr;   // command addressed to terminal 31
        logic access_opt;   // descriptor entry has access interrupt on
    } rtie_cmd_s;

    // host register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } rtie_host_s;

endpackage

/* rtie_sticky.sv */
/*
 * Sticky bit vector: set bits accumulate until a clear strobe.
 * Assumes set and clear are synchronous one-cycle strobes.
 */
module rtie_sticky #(
    parameter int W = 16
) (
    input wire logic clk_in,            // block clock
    input wire logic arst_n_in,         // async reset, active low
    input wire logic [W-1:0] set_in,    // bits to set this cycle
    input wire logic clr_in,            // clear all bits
    output logic [W-1:0] q_out          // stored bits
);

    logic [W-1:0] q;
    logic [W-1:0] next_q;

    // a set landing in the clearing cycle survives the clear
    always_comb
    begin
        next_q = (clr_in ? '0 : q) | set_in;
    end

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            q <= '0;
        else
            q <= next_q;
    end

    assign q_out = q;

endmodule

/* rtie_host_model.sv */
/*
 * Host processor model: word writes and reads on the register port.
 * Assumes one caller at a time; each task first waits for a rising edge.
 */
module rtie_host_model (
    input wire logic clk_in,                  // block clock
    output rtie_pkg::rtie_host_s host_out     // register access
);
    initial host_out = '0;

    // strobe held through the taking edge, dropped just after it
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        host_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_in);
        host_out.wr <= 1'b0;
    endtask

    // returns just after the taking edge, where read data has landed
    task automatic rd(input logic [7:0] a);
        @(posedge clk_in);
        host_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk_in);
        host_out.rd <= 1'b0;
        #1;
    endtask
endmodule

/* rtie_top_test.sv */
/*
 * Self-checking bench for the terminal interrupt event registers.
 * Assumes a 10 MHz clock and drives all pulses for one cycle.
 */
module rtie_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    rtie_pkg::rtie_host_s host;
    rtie_pkg::rtie_cmd_s cmd = '0;
    logic bcast_en = 1'b0, ix = 1'b0, circ = 1'b0, me = 1'b0;
    logic done = 1'b0, cfg = 1'b0, ack = 1'b0;
    logic [15:0] rd_data;
    logic irq_n, req, auto_rst, me_flag, no_data;
    int bad_count = 0, checked = 0;
    int en, oen, pend, armed, irq_m, req_m, auto_m, me_m, w;
    logic [7:0] w_list[4] = '{rtie_pkg::PENDING_ADDR, rtie_pkg::ENABLE_ADDR,
                             rtie_pkg::OUT_ENABLE_ADDR, 8'h00};

    initial forever #50 clk = ~clk;

    rtie_host_model host_u (.clk_in(clk), .host_out(host));

    rtie_top dut_u (.CLK_IN(clk), .ARST_N_IN(arst_n), .HOST_IN(host),
        .CMD_IN(cmd), .BCAST_EN_IN(bcast_en), .INDEX_ZERO_IN(ix),
        .CIRC_DONE_IN(circ), .ME_SET_IN(me), .MSG_DONE_IN(done),
        .CFG_AUTO_RESET_IN(cfg), .RESET_ACK_IN(ack),
        .RD_DATA_OUT(rd_data), .IRQ_N_OUT(irq_n), .RESET_REQ_OUT(req),
        .RESET_AUTO_OUT(auto_rst), .ME_FLAG_OUT(me_flag),
        .NO_DATA_OUT(no_data));

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // one event cycle, then the model follows and irq_n, me_flag, no_data and the reset pins compared
    task automatic step(input rtie_pkg::rtie_cmd_s c, input logic x, y,
                        input logic m, d);
        int ev;
        @(posedge clk);
        cmd <= c;
        ix <= x;
        circ <= y;
        me <= m;
        done <= d;
        @(posedge clk);
        cmd <= '0;
        {ix, circ, me, done} <= 4'h0;
        ev = 0;
        if (c.valid && c.reset_mc) ev |= 1 << 8;
        if (x || y) ev |= 1 << 7;
        if (c.valid && c.illegal) ev |= 'h50;
        if (c.valid && c.bcast_addr && bcast_en) ev |= 1 << 5;
        if (m) ev |= 1 << 4;
        if (c.valid && c.access_opt) ev |= 1 << 3;
        pend |= ev & en;
        armed |= ev & en & oen;
        if (d && armed != 0) irq_m = 1;
        if (c.valid && c.illegal) me_m = 1;
        else if (d) me_m = 0;
        if (c.valid && c.reset_mc && (!en[8] || c.bcast_addr))
        begin
            req_m = 1;
            auto_m = cfg;
        end
        #1;
        check("irq_n", 16'(irq_n), 16'(!irq_m));
        check("me_flag", 16'(me_flag), 16'(me_m));
        check("no_data", 16'(no_data), 16'(me_m));
        check("reset_req", 16'(req), 16'(req_m));
        if (req_m) check("reset_auto", 16'(auto_rst), 16'(auto_m));
    endtask

    initial
    begin
        #(5000 * 100);
        bad_count++;
        print_verdict();
    end

    initial
    begin
        void'($urandom(61497));
        {pend, armed, irq_m, req_m, auto_m, me_m} = '0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        foreach (w_list[i])
        begin
            host_u.rd(w_list[i]);
            check("rd_reset", rd_data, 16'h0000);
        end
        check("irq_reset", 16'(irq_n), 16'h0001);
        host_u.wr(rtie_pkg::ENABLE_ADDR, 16'hFFFF);
        host_u.rd(rtie_pkg::ENABLE_ADDR);
        check("enable", rd_data, 16'h01F8);
        host_u.wr(rtie_pkg::OUT_ENABLE_ADDR, 16'hFFFF);
        host_u.rd(rtie_pkg::OUT_ENABLE_ADDR);
        check("out_enable", rd_data, 16'h01F8);
        host_u.wr(rtie_pkg::PENDING_ADDR, 16'hFFFF);
        host_u.rd(rtie_pkg::PENDING_ADDR);
        check("pending_wr", rd_data, 16'h0000);
        host_u.rd(8'h00);
        check("unmapped", rd_data, 16'h0000);
        repeat (60)
        begin
            w = $urandom;
            en = w & 'h1F8;
            host_u.wr(rtie_pkg::ENABLE_ADDR, 16'(w));
            w = $urandom;
            oen = w & 'h1F8;
            host_u.wr(rtie_pkg::OUT_ENABLE_ADDR, 16'(w));
            bcast_en <= 1'($urandom);
            cfg <= 1'($urandom);
            host_u.rd(rtie_pkg::ENABLE_ADDR);
            check("enable", rd_data, 16'(en));
            repeat (3)
                step(5'($urandom), 1'($urandom), 1'($urandom),
                     1'($urandom), 1'b0);
            step('0, 1'b0, 1'b0, 1'b0, 1'b1);
            host_u.rd(rtie_pkg::PENDING_ADDR);
            check("pending", rd_data, 16'(pend));
            check("pend_reset", 16'(rd_data[8]), 16'(pend[8]));
            check("pend_index", 16'(rd_data[7]), 16'(pend[7]));
            check("pend_illegal", 16'(rd_data[6]), 16'(pend[6]));
            check("pend_bcast", 16'(rd_data[5]), 16'(pend[5]));
            check("pend_msg_err", 16'(rd_data[4]), 16'(pend[4]));
            check("pend_access", 16'(rd_data[3]), 16'(pend[3]));
            check("irq_clear", 16'(irq_n), 16'h0001);
            host_u.rd(rtie_pkg::PENDING_ADDR);
            check("pending_clr", rd_data, 16'h0000);
            {pend, armed, irq_m} = '0;
            if (req_m)
            begin
                @(posedge clk);
                ack <= 1'b1;
                @(posedge clk);
                ack <= 1'b0;
                #1;
                req_m = 0;
                check("reset_ack", 16'(req), 16'h0000);
            end
        end
        // reset again in mid-run: registers and pins must come back
        host_u.wr(rtie_pkg::ENABLE_ADDR, 16'hFFFF);
        host_u.rd(rtie_pkg::ENABLE_ADDR);
        check("enable_full", rd_data, 16'h01F8);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        check("rd_rerst", rd_data, 16'h0000);
        check("irq_rerst", 16'(irq_n), 16'h0001);
        check("req_rerst", 16'(req), 16'h0000);
        check("me_rerst", 16'(me_flag), 16'h0000);
        host_u.rd(rtie_pkg::ENABLE_ADDR);
        check("enable_rerst", rd_data, 16'h0000);
        host_u.rd(rtie_pkg::OUT_ENABLE_ADDR);
        check("out_en_rerst", rd_data, 16'h0000);
        print_verdict();
    end

endmodule
